// ===== inc/arcdr_map.svh
// Constant map for the asynchronous receive clock and data recovery block
`ifndef ARCDR_MAP_SVH
`define ARCDR_MAP_SVH
// Samples per bit
`define ARCDR_SPB_NORMAL 5'd16
`define ARCDR_SPB_DOUBLE 5'd8
// Centre voting samples, normal mode
`define ARCDR_VOTE_N_FIRST 5'd8
`define ARCDR_VOTE_N_MID 5'd9
`define ARCDR_VOTE_N_LAST 5'd10
// Centre voting samples, double speed mode
`define ARCDR_VOTE_D_FIRST 5'd4
`define ARCDR_VOTE_D_MID 5'd5
`define ARCDR_VOTE_D_LAST 5'd6
// Extra samples before rehunting in double speed mode
`define ARCDR_DOUBLE_REARM 5'd1
// Frame length limits, data plus parity
`define ARCDR_BITS_MIN 4'd5
`define ARCDR_BITS_MAX 4'd10
`define ARCDR_BITS_RST 4'd8
// Baud divisor reset value
`define ARCDR_DIV_RST 12'h000
`endif

// ===== inc/arcdr_pkg.sv
// Types for the asynchronous receive clock and data recovery block
package arcdr_pkg;
  typedef enum logic [2:0] {
    ARCDR_HUNT = 3'b000,
    ARCDR_START = 3'b001,
    ARCDR_BITS = 3'b010,
    ARCDR_STOP = 3'b011,
    ARCDR_REARM = 3'b100
  } arcdr_state_t;
endpackage : arcdr_pkg

// ===== core/arcdr_tick_gen.sv
// Baud sample tick divider
`timescale 1ns/1ps
`default_nettype none
module arcdr_tick_gen #(
  parameter int DIV_W = 12
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic clk_en_i,
  // Divisor
  input wire logic [DIV_W-1:0] baud_divisor_value_i,
  // Sample tick
  output logic tick_o
);
  logic [DIV_W-1:0] cnt_reg;

  // Count down; tick every divisor+1 clocks
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_reg <= '0;
      tick_o <= 1'b0;
    end else if (clk_en_i) begin
      if (cnt_reg == '0) begin
        cnt_reg <= baud_divisor_value_i;
        tick_o <= 1'b1;
      end else begin
        cnt_reg <= cnt_reg - 1'b1;
        tick_o <= 1'b0;
      end
    end
  end
endmodule : arcdr_tick_gen
`default_nettype wire

// ===== core/arcdr_fifo.sv
// Small valid/ready FIFO for received frames
`timescale 1ns/1ps
`default_nettype none
module arcdr_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic clk_en_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0] cnt_reg;
  logic push;
  logic pop;

  // Handshakes
  assign in_ready_o = (cnt_reg != (AW + 1)'(DEPTH));
  assign out_valid_o = (cnt_reg != '0);
  assign out_data_o = mem[rd_reg];
  assign push = in_valid_i && in_ready_o && clk_en_i;
  assign pop = out_valid_o && out_ready_i && clk_en_i;

  // Storage, no reset needed
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_reg] <= in_data_i;
    end
  end

  // Pointers and fill count
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
      end
      if (push && !pop) begin
        cnt_reg <= cnt_reg + 1'b1;
      end else if (pop && !push) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end
endmodule : arcdr_fifo
`default_nettype wire

// ===== core/arcdr_rx.sv
// Asynchronous receive clock and data recovery, top level
// Functional notes
// RULE1: The line is sampled sixteen times per bit, or eight times in double speed.
// RULE2: Double speed applies when the double speed select input is one.
// RULE3: A high to low line change starts start bit checking, the first low sample is one; the code starts on any low sample while hunting.
// RULE4: Start validity uses samples 8, 9, 10, or 4, 5, 6 in double speed.
// RULE5: Two or more high validation samples reject the start as noise and hunting resumes.
// RULE6: A valid start bit realigns bit timing, afresh for every frame.
// RULE7: Each bit runs a sequence of sixteen or eight states, samples numbered by state.
// RULE8: Each bit value is the majority of its three centre samples.
// RULE9: Recovery runs through data and parity up to the first stop bit; later stops are ignored.
// RULE10: A stop bit voted zero raises the frame error for that frame.
// RULE11: In normal mode hunting restarts right after the last stop voting sample.
// RULE12: Frames of five to ten data plus parity bits are handled.
// RULE13: The remote transmitter keeps its bit rate error small, near two percent.
// RULE14: Double speed changes the sample divider from sixteen to eight, doubling bit rate.
// RULE15: In double speed hunting restarts a short interval after the last stop voting sample.
// RULE16: The serial input is synchronised to the clock before start detection.
`timescale 1ns/1ps
`default_nettype none
`include "arcdr_map.svh"
module arcdr_rx #(
  parameter int DIV_W = 12,
  parameter int DEPTH = 32
) (
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic clk_en_i,
  // Configuration
  input wire logic double_speed_select_i,
  input wire logic [DIV_W-1:0] baud_divisor_value_i,
  input wire logic [3:0] frame_bits_i,
  // Serial line
  input wire logic rxd_i,
  // Received frames
  output logic rx_valid_o,
  input wire logic rx_ready_i,
  output logic [9:0] receive_data_buffer_o,
  output logic frame_error_flag_o,
  // Status
  output logic overrun_o,
  output logic busy_o
);
  import arcdr_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Majority of three samples
  function automatic logic vote3(input logic [2:0] s);
    vote3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction : vote3

  // Clamp frame length into the handled range
  // Out of range lengths are clamped, not refused
  function automatic logic [3:0] clamp_bits(input logic [3:0] b);
    if (b < `ARCDR_BITS_MIN) begin
      clamp_bits = `ARCDR_BITS_MIN;
    end else if (b > `ARCDR_BITS_MAX) begin
      clamp_bits = `ARCDR_BITS_MAX;
    end else begin
      clamp_bits = b;
    end
  endfunction : clamp_bits

  // ----------------------------------------------------------------
  // Input synchroniser and sample tick
  // ----------------------------------------------------------------
  logic sync1_reg;
  logic sync2_reg;
  logic tick;

  // RULE16 two flop synchroniser
  // Reset high so an idle line does not look like a start
  // Costs two clocks of latency on every line edge
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
    end else if (clk_en_i) begin
      sync1_reg <= rxd_i;
      sync2_reg <= sync1_reg;
    end
  end

  // RULE14 sample divider; per-bit ratio set by sample count below
  // A divisor of zero gives a tick on every enabled clock
  arcdr_tick_gen #(
    .DIV_W(DIV_W)
  ) u_tick (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .clk_en_i(clk_en_i),
    .baud_divisor_value_i(baud_divisor_value_i),
    .tick_o(tick)
  );

  // ----------------------------------------------------------------
  // Mode dependent sample numbers
  // ----------------------------------------------------------------
  logic [4:0] spb;
  logic [4:0] v_first;
  logic [4:0] v_mid;
  logic [4:0] v_last;

  // RULE1 RULE2 sample rate and voting points by mode
  always_comb begin
    if (double_speed_select_i == 1'b1) begin
      spb = `ARCDR_SPB_DOUBLE;
      v_first = `ARCDR_VOTE_D_FIRST;
      v_mid = `ARCDR_VOTE_D_MID;
      v_last = `ARCDR_VOTE_D_LAST;
    end else begin
      spb = `ARCDR_SPB_NORMAL;
      v_first = `ARCDR_VOTE_N_FIRST;
      v_mid = `ARCDR_VOTE_N_MID;
      v_last = `ARCDR_VOTE_N_LAST;
    end
  end

  // ----------------------------------------------------------------
  // Recovery state machine
  // ----------------------------------------------------------------
  arcdr_state_t state_reg;
  logic [4:0] samp_reg;
  logic [2:0] votes_reg;
  logic [3:0] bit_idx_reg;
  logic [3:0] nbits_reg;
  logic [9:0] shift_reg;
  logic push_reg;
  logic [10:0] push_data_reg;
  logic fifo_in_ready;
  logic [2:0] votes_now;
  logic bit_val;

  // Votes including the current sample
  always_comb begin
    votes_now = votes_reg;
    if (samp_reg == v_first) begin
      votes_now[0] = sync2_reg;
    end
    if (samp_reg == v_mid) begin
      votes_now[1] = sync2_reg;
    end
    if (samp_reg == v_last) begin
      votes_now[2] = sync2_reg;
    end
    bit_val = vote3(votes_now);
  end

  // Sequencer; only advances on sample ticks
  // Limitation: a mode change in mid frame moves the vote points at once
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_reg <= ARCDR_HUNT;
      samp_reg <= 5'h0_0;
      votes_reg <= 3'b000;
      bit_idx_reg <= 4'h0;
      nbits_reg <= `ARCDR_BITS_RST;
      shift_reg <= 10'h000;
      push_reg <= 1'b0;
      push_data_reg <= 11'h000;
    end else if (clk_en_i) begin
      // Hold a frame until the FIFO takes it
      if (push_reg && fifo_in_ready) begin
        push_reg <= 1'b0;
      end
      if (tick) begin
        votes_reg <= votes_now;
        case (state_reg)
          ARCDR_HUNT: begin
            // RULE3 first low sample is sample one
            if (!sync2_reg) begin
              state_reg <= ARCDR_START;
              samp_reg <= 5'd2;
              // RULE12 frame length latched per frame
              nbits_reg <= clamp_bits(frame_bits_i);
            end
          end
          ARCDR_START: begin
            samp_reg <= samp_reg + 5'd1;
            // RULE4 decide after the last validation sample
            if (samp_reg == v_last) begin
              // RULE5 majority high means noise
              if (bit_val) begin
                state_reg <= ARCDR_HUNT;
              end else begin
                // RULE6 timing aligned to this start bit
                state_reg <= ARCDR_BITS;
                bit_idx_reg <= 4'h0;
              end
            end
            // RULE7 wrap at the end of the start bit
            if (samp_reg == spb) begin
              samp_reg <= 5'd1;
            end
          end
          ARCDR_BITS: begin
            // RULE7 state number equals sample number
            samp_reg <= (samp_reg == spb) ? 5'd1 : samp_reg + 5'd1;
            if (samp_reg == v_last) begin
              // RULE8 majority of centre samples
              shift_reg[bit_idx_reg] <= bit_val;
              bit_idx_reg <= bit_idx_reg + 4'h1;
              if (bit_idx_reg == nbits_reg - 4'h1) begin
                state_reg <= ARCDR_STOP;
              end
            end
          end
          ARCDR_STOP: begin
            samp_reg <= (samp_reg == spb) ? 5'd1 : samp_reg + 5'd1;
            // RULE9 first stop bit only
            // Later stop bits are never sampled
            if (samp_reg == v_last) begin
              // RULE10 stop voted zero flags frame error
              push_data_reg <= {~bit_val, shift_reg};
              push_reg <= 1'b1;
              // RULE11 normal mode rehunts at once
              // RULE15 double speed waits a short interval
              state_reg <= double_speed_select_i ? ARCDR_REARM : ARCDR_HUNT;
              samp_reg <= 5'h0_0;
            end
          end
          ARCDR_REARM: begin
            // RULE15 deaf for the rearm interval
            samp_reg <= samp_reg + 5'd1;
            if (samp_reg + 5'd1 >= `ARCDR_DOUBLE_REARM) begin
              state_reg <= ARCDR_HUNT;
            end
          end
          default: begin
            state_reg <= ARCDR_HUNT;
          end
        endcase
        // Clear votes on a new bit
        // High default keeps a half filled vote from faking a low
        if (samp_reg == spb || state_reg == ARCDR_HUNT) begin
          votes_reg <= 3'b111;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Frame FIFO and outputs
  // ----------------------------------------------------------------
  logic fifo_out_valid;
  logic [10:0] fifo_out_data;
  logic out_take;

  arcdr_fifo #(
    .WIDTH(11),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .clk_en_i(clk_en_i),
    .in_valid_i(push_reg),
    .in_ready_o(fifo_in_ready),
    .in_data_i(push_data_reg),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(out_take),
    .out_data_o(fifo_out_data)
  );

  // Output skid: pull a word when the output slot is free
  // Registered slot keeps every top output on a flop
  // Costs one clock of latency per word
  assign out_take = !rx_valid_o || rx_ready_i;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rx_valid_o <= 1'b0;
      receive_data_buffer_o <= 10'h000;
      frame_error_flag_o <= 1'b0;
    end else if (clk_en_i && out_take) begin
      rx_valid_o <= fifo_out_valid;
      if (fifo_out_valid) begin
        receive_data_buffer_o <= fifo_out_data[9:0];
        frame_error_flag_o <= fifo_out_data[10];
      end
    end
  end

  // Overrun when a finished frame meets a pending word the full FIFO has not taken; sticky until reset
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      overrun_o <= 1'b0;
      busy_o <= 1'b0;
    end else if (clk_en_i) begin
      // Drop only when a finished stop vote meets a still pending word
      // The older pending word is lost; the newest frame is kept
      if (tick && state_reg == ARCDR_STOP && samp_reg == v_last) begin
        if (push_reg && !fifo_in_ready) begin
          overrun_o <= 1'b1;
        end
      end
      busy_o <= (state_reg != ARCDR_HUNT);
    end
  end
endmodule : arcdr_rx
`default_nettype wire

// ===== test/arcdr_rx_monitor.sv
// Port checker for the receive recovery block
`timescale 1ns/1ps
`default_nettype none
module arcdr_rx_monitor #(
  parameter int DIV_W = 12,
  parameter int DEPTH = 32
) (
  // Watched ports
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic clk_en_i,
  input wire logic double_speed_select_i,
  input wire logic [DIV_W-1:0] baud_divisor_value_i,
  input wire logic [3:0] frame_bits_i,
  input wire logic rxd_i,
  input wire logic rx_valid_o,
  input wire logic rx_ready_i,
  input wire logic [9:0] receive_data_buffer_o,
  input wire logic frame_error_flag_o,
  input wire logic overrun_o,
  input wire logic busy_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // Held word waits for the consumer
  property p_hold;
    rx_valid_o && !rx_ready_i && clk_en_i |=> rx_valid_o && $stable(receive_data_buffer_o);
  endproperty
  a_hold: assert property (p_hold) else $error("word dropped before accept");
  property p_fe_hold;
    rx_valid_o && !rx_ready_i |=> $stable(frame_error_flag_o);
  endproperty
  a_fe_hold: assert property (p_fe_hold) else $error("frame error moved while held");
  property p_data_src;
    $changed(receive_data_buffer_o) |-> rx_valid_o;
  endproperty
  a_data_src: assert property (p_data_src) else $error("data changed without word");
  property p_ovr_sticky;
    overrun_o |=> overrun_o;
  endproperty
  a_ovr_sticky: assert property (p_ovr_sticky) else $error("overrun cleared");
  property p_ovr_cause;
    $rose(overrun_o) |-> $past(rx_valid_o);
  endproperty
  a_ovr_cause: assert property (p_ovr_cause) else $error("overrun with free output");
  // Frozen enable holds valid, busy and overrun
  property p_freeze;
    !clk_en_i |=> $stable(rx_valid_o) && $stable(busy_o) && $stable(overrun_o);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while frozen");
  property p_start;
    !busy_o && clk_en_i && baud_divisor_value_i == 0 && $fell(rxd_i) |-> ##[1:5] busy_o;
  endproperty
  a_start: assert property (p_start) else $error("falling edge not taken");
  // Idle line seen through both sync flops keeps the receiver hunting
  property p_idle;
    !busy_o && $past(rxd_i, 3) && $past(clk_en_i) && $past(clk_en_i, 2)
      && $past(clk_en_i, 3) |=> !busy_o;
  endproperty
  a_idle: assert property (p_idle) else $error("start taken on an idle line");
  c_word: cover property ($rose(rx_valid_o));
  c_ferr: cover property (rx_valid_o && frame_error_flag_o);
  c_ovr: cover property ($rose(overrun_o));
endmodule : arcdr_rx_monitor
bind arcdr_rx arcdr_rx_monitor #(.DIV_W(DIV_W), .DEPTH(DEPTH)) u_mon (.clk_i, .rst_b_i,
  .clk_en_i, .double_speed_select_i, .baud_divisor_value_i, .frame_bits_i, .rxd_i,
  .rx_valid_o, .rx_ready_i, .receive_data_buffer_o, .frame_error_flag_o, .overrun_o, .busy_o);
`default_nettype wire

// ===== test/arcdr_tx_model.sv
// Remote serial transmitter model driving the receive line
`timescale 1ns/1ps
`default_nettype none
module arcdr_tx_model (
  // Clock
  input wire logic clk_i,
  // Serial line, idle high
  output logic rxd_o
);
  initial rxd_o = 1'b1;
  // Level for n clocks, one clock flipped at fp
  task automatic hold(input logic v, input int n, input int fp);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      rxd_o <= (i == fp) ? ~v : v;
    end
  endtask : hold
  // whole frame, bit time near nominal
  task automatic send(input logic [9:0] d, input int n, input int bc, input logic stp,
                      input int sc, input int fp);
    hold(1'b0, bc, -1);
    for (int b = 0; b < n; b++) begin
      hold(d[b], bc, fp);
    end
    hold(stp, sc, -1);
    // Broken stop must not leave the line low
    if (!stp) begin
      hold(1'b1, bc, -1);
    end
  endtask : send
endmodule : arcdr_tx_model
`default_nettype wire

// ===== test/async_rx_clock_data_recovery_tb_top.sv
// Self-checking bench for the receive recovery block
`timescale 1ns/1ps
`default_nettype none
module async_rx_clock_data_recovery_tb_top;
  logic clk_i, rst_b_i, clk_en_i, ds_i, rx_ready_i, stall, rxd;
  logic [11:0] div_i;
  logic [3:0] frame_bits_i;
  logic rx_valid_o, fe_o, overrun_o, busy_o;
  logic [9:0] data_o;
  logic [20:0] e;
  logic [20:0] exp_q[$];
  int failures, compares;
  arcdr_tx_model m (.clk_i(clk_i), .rxd_o(rxd));
  arcdr_rx #(.DIV_W(12), .DEPTH(32)) dut (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .clk_en_i(clk_en_i), .double_speed_select_i(ds_i), .baud_divisor_value_i(div_i),
    .frame_bits_i(frame_bits_i), .rxd_i(rxd), .rx_valid_o(rx_valid_o),
    .rx_ready_i(rx_ready_i), .receive_data_buffer_o(data_o), .frame_error_flag_o(fe_o),
    .overrun_o(overrun_o), .busy_o(busy_o));
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  task automatic check(input string nm, input logic [10:0] ex, input logic [10:0] got);
    compares++;
    if (got !== ex) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, ex, got);
    end
  endtask : check
  task automatic finish_test();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : finish_test
  // Note the expected word, then let the far side send it
  task automatic frame(input int n, input int bc, input logic stp, input int sc,
                       input int fp, input bit keep);
    logic [9:0] d, msk;
    d = 10'($urandom);
    msk = 10'((1 << n) - 1);
    if (keep) exp_q.push_back({msk, ~stp, d & msk});
    frame_bits_i <= 4'(n);
    m.send(d, n, bc, stp, sc, fp);
  endtask : frame
  task automatic drain();
    for (int i = 0; i < 9000 && exp_q.size() > 0; i++) @(posedge clk_i);
  endtask : drain
  // Consumer with random back-pressure
  always @(posedge clk_i) rx_ready_i <= !stall && ($urandom % 4 != 0);
  // Oldest note against each accepted word
  always @(posedge clk_i) begin
    if (rx_valid_o && rx_ready_i) begin
      if (exp_q.size() == 0) begin
        check("spare word", 11'h0, 11'h1);
      end else begin
        e = exp_q.pop_front();
        check("word", e[10:0], {fe_o, data_o & e[20:11]});
      end
    end
  end
  initial begin
    repeat (60000) @(posedge clk_i);
    failures++;
    finish_test();
  end
  initial begin
    {rst_b_i, ds_i, stall} = 3'b000;
    {clk_en_i, div_i, frame_bits_i} = {1'b1, 12'h000, 4'h8};
    void'($urandom(40));
    repeat (8) @(posedge clk_i);
    rst_b_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    // Both speeds, all lengths, early restart in normal speed and centre flips
    for (int s = 0; s < 2; s++) begin
      ds_i <= s[0];
      for (int n = 5; n <= 10; n++) frame(n, 16 >> s, 1'b1, s ? 8 : 11, n[0] ? 7 >> s : -1, 1);
      frame(8, 16 >> s, 1'b0, 16 >> s, -1, 1);
      m.hold(1'b0, 8 >> s, -1);
      // Glitch must end high, or the line left low reads as a real start
      m.hold(1'b1, 30, -1);
      check("busy", 11'h0, {10'h0, busy_o});
      frame(9, 16 >> s, 1'b1, 16 >> s, -1, 1);
      drain();
    end
    clk_en_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    clk_en_i <= 1'b1;
    // Slow divisor with transmitter off by one clock a bit
    {ds_i, div_i} <= {1'b0, 12'h003};
    frame(8, 65, 1'b1, 65, -1, 1);
    frame(8, 63, 1'b1, 63, -1, 1);
    drain();
    // Fill the buffer until frames are dropped
    {stall, div_i} <= {1'b1, 12'h000};
    // Slot, FIFO and pending word hold 34; frame 34 overwrites the pending one
    for (int i = 0; i < 35; i++) frame(8, 16, 1'b1, 16, -1, i != 33);
    repeat (10) @(posedge clk_i);
    check("overrun", 11'h1, {10'h0, overrun_o});
    stall <= 1'b0;
    drain();
    check("left words", 11'h0, 11'(exp_q.size()));
    finish_test();
  end
endmodule : async_rx_clock_data_recovery_tb_top
`default_nettype wire
